// File: pkg/rdasc_pkg.sv
// constants for the remote display alarm and serial control block
package rdasc_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD_MIN_BPS = 300;
  // bit time at the slowest rate, rounded down; faster rates halve it
  localparam int BIT_CYCLES_300 = CLK_HZ / BAUD_MIN_BPS;
  localparam int TMR_W = 19;
  localparam logic [2:0] BAUD_SEL_MAX = 3'h6;
  localparam logic [2:0] BAUD_SEL_RST = 3'h5;
  localparam int AW = 6;
  localparam logic [AW-1:0] OFF_CTRL = 6'h00;
  localparam logic [AW-1:0] OFF_SERIAL = 6'h04;
  localparam logic [AW-1:0] OFF_A1_LOW = 6'h08;
  localparam logic [AW-1:0] OFF_A1_HIGH = 6'h0C;
  localparam logic [AW-1:0] OFF_A2_LOW = 6'h10;
  localparam logic [AW-1:0] OFF_A2_HIGH = 6'h14;
  localparam logic [AW-1:0] OFF_VALUE = 6'h18;
  localparam logic [AW-1:0] OFF_STATE = 6'h1C;
  localparam logic [AW-1:0] OFF_IRQ_STAT = 6'h20;
  localparam logic [AW-1:0] OFF_IRQ_CLR = 6'h24;
  localparam logic [AW-1:0] OFF_IRQ_EN = 6'h28;
  localparam logic [AW-1:0] OFF_ALM_RST = 6'h2C;
  localparam logic [AW-1:0] OFF_RX_DATA = 6'h30;
  localparam int CTRL_A1_EN = 0;
  localparam int CTRL_A2_EN = 1;
  localparam int CTRL_A1_MODE = 2;
  localparam int CTRL_A2_MODE = 4;
  localparam int CTRL_LATCH = 6;
  localparam int CTRL_A1_COL = 8;
  localparam int CTRL_A2_COL = 10;
  localparam int CTRL_IDLE_COL = 12;
  localparam logic [13:0] CTRL_RST = 14'h0500;
  localparam int SER_HOST = 0;
  localparam int SER_BAUD = 1;
  localparam int SER_FMT = 4;
  localparam int SER_STD = 6;
  localparam int SER_ADDR = 8;
  localparam logic [1:0] MODE_LOW = 2'h0;
  localparam logic [1:0] MODE_HIGH = 2'h1;
  localparam logic [1:0] COL_GREEN = 2'h0;
  localparam logic [1:0] COL_RED = 2'h1;
  localparam logic [1:0] COL_AMBER = 2'h2;
  localparam logic [1:0] FMT_7O1 = 2'h0;
  localparam logic [1:0] FMT_7E1 = 2'h1;
  localparam logic [1:0] FMT_8N1 = 2'h2;
  localparam logic [1:0] STD_232 = 2'h0;
  localparam logic [1:0] STD_422 = 2'h1;
  localparam logic [1:0] STD_485 = 2'h2;
  localparam logic [7:0] ADDR_MAX = 8'hC7;
  localparam logic [7:0] CMD_SEND = 8'h3F;
  localparam logic [15:0] THR_MIN = 16'hFC19;
  localparam logic [15:0] THR_MAX = 16'h270F;
  localparam logic [15:0] THR_LOW_RST = 16'h0000;
  localparam logic [15:0] THR_HIGH_RST = 16'h03E8;
  localparam int IRQ_W = 5;
endpackage : rdasc_pkg

// File: src/rdasc_alarm.sv
// one alarm comparator with latched or unlatched output
`timescale 1ns/1ps
module rdasc_alarm import rdasc_pkg::*; (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic enable_in,
  input wire logic [1:0] mode_in,
  input wire logic latched_in,
  input wire logic clear_in,
  input wire logic signed [15:0] value_in,
  input wire logic signed [15:0] low_in,
  input wire logic signed [15:0] high_in,
  output logic active_out
);
  logic below;
  logic above;
  logic cond;
  assign below = value_in < low_in;
  assign above = value_in > high_in;
  always_comb begin
    unique case (mode_in)
      MODE_LOW: cond = below;
      MODE_HIGH: cond = above;
      default: cond = below | above;
    endcase
  end
  // a new trigger beats a clear arriving in the same cycle
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      active_out <= 1'b0;
    end else begin
      active_out <= enable_in & (cond | (active_out & latched_in & ~clear_in));
    end
  end
endmodule : rdasc_alarm

// File: src/rdasc_top.sv
// remote display control: alarms, colour choice, serial settings and link
`timescale 1ns/1ps
module rdasc_top import rdasc_pkg::*; #(
  parameter int BIT_CYCLES_SLOW = BIT_CYCLES_300
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic menu_in,
  input wire logic key_up_in,
  input wire logic key_down_in,
  input wire logic rxd_in,
  output logic txd_out,
  output logic tx_oe_out,
  output logic [1:0] alarm_out,
  output logic [1:0] colour_out,
  output logic [15:0] display_value_out,
  output logic irq_out
);
  typedef enum logic [1:0] {TX_IDLE, TX_HI, TX_LO} rdasc_tx_state_t;

  logic resp_reg;
  logic [31:0] rdata_reg;
  logic wr_go;
  logic [13:0] ctrl_reg;
  logic [15:0] serial_reg;
  logic [15:0] a1_low_reg;
  logic [15:0] a1_high_reg;
  logic [15:0] a2_low_reg;
  logic [15:0] a2_high_reg;
  logic [15:0] value_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  logic [7:0] rx_data_reg;
  logic [1:0] alarm_act;
  logic [1:0] alarm_prev_reg;
  logic alarm_clear;
  logic host_flow;
  logic [2:0] baud_sel;
  logic [1:0] fmt_sel;
  logic [1:0] std_sel;
  logic [7:0] addr_sel;
  logic [TMR_W-1:0] bit_cycles;
  logic tx_start;
  logic [7:0] tx_data;
  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_err;
  logic rx_accept;
  logic addr_armed_reg;
  logic req_pending_reg;
  logic frame_done;
  logic frame_go;
  logic [15:0] frame_val_reg;
  rdasc_tx_state_t tx_state_reg;

  // clamp a threshold write into the displayable range
  function automatic logic [15:0] clamp_thr(input logic [15:0] v);
    if ($signed(v) < $signed(THR_MIN)) begin
      return THR_MIN;
    end else if ($signed(v) > $signed(THR_MAX)) begin
      return THR_MAX;
    end
    return v;
  endfunction : clamp_thr

  // ---------------- bus slave: one wait state per access
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~resp_reg;
  assign wr_go = avs_write_in & resp_reg;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      resp_reg <= 1'b0;
    end else begin
      resp_reg <= (avs_read_in | avs_write_in) & ~resp_reg;
    end
  end

  // read data captured in the wait cycle, stands at the accepting edge
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_in && !resp_reg) begin
      unique case (avs_address_in)
        OFF_CTRL: rdata_reg <= {18'h0, ctrl_reg};
        OFF_SERIAL: rdata_reg <= {16'h0, serial_reg};
        OFF_A1_LOW: rdata_reg <= {{16{a1_low_reg[15]}}, a1_low_reg};
        OFF_A1_HIGH: rdata_reg <= {{16{a1_high_reg[15]}}, a1_high_reg};
        OFF_A2_LOW: rdata_reg <= {{16{a2_low_reg[15]}}, a2_low_reg};
        OFF_A2_HIGH: rdata_reg <= {{16{a2_high_reg[15]}}, a2_high_reg};
        OFF_VALUE: rdata_reg <= {{16{value_reg[15]}}, value_reg};
        OFF_STATE: rdata_reg <= {24'h0, tx_oe_out, addr_armed_reg, req_pending_reg,
                                 tx_busy, colour_out, alarm_act};
        OFF_IRQ_STAT: rdata_reg <= {27'h0, irq_stat_reg};
        OFF_IRQ_EN: rdata_reg <= {27'h0, irq_en_reg};
        OFF_RX_DATA: rdata_reg <= {24'h0, rx_data_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata_out = rdata_reg;

  // ---------------- configuration registers
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_go && avs_address_in == OFF_CTRL) begin
      ctrl_reg <= avs_writedata_in[13:0];
      // unused colour code falls back to amber
      if (avs_writedata_in[CTRL_A1_COL +: 2] == 2'h3) begin
        ctrl_reg[CTRL_A1_COL +: 2] <= COL_AMBER;
      end
      if (avs_writedata_in[CTRL_A2_COL +: 2] == 2'h3) begin
        ctrl_reg[CTRL_A2_COL +: 2] <= COL_AMBER;
      end
      if (avs_writedata_in[CTRL_IDLE_COL +: 2] == 2'h3) begin
        ctrl_reg[CTRL_IDLE_COL +: 2] <= COL_AMBER;
      end
    end
  end

  // serial settings; out-of-range selections clamp to the last legal one
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      serial_reg <= {8'h00, STD_232, FMT_8N1, BAUD_SEL_RST, 1'b0};
    end else if (wr_go && avs_address_in == OFF_SERIAL) begin
      serial_reg[SER_HOST] <= avs_writedata_in[SER_HOST];
      serial_reg[SER_BAUD +: 3] <= (avs_writedata_in[SER_BAUD +: 3] > BAUD_SEL_MAX) ?
        BAUD_SEL_MAX : avs_writedata_in[SER_BAUD +: 3];
      serial_reg[SER_FMT +: 2] <= (avs_writedata_in[SER_FMT +: 2] > FMT_8N1) ?
        FMT_8N1 : avs_writedata_in[SER_FMT +: 2];
      serial_reg[SER_STD +: 2] <= (avs_writedata_in[SER_STD +: 2] > STD_485) ?
        STD_485 : avs_writedata_in[SER_STD +: 2];
      serial_reg[SER_ADDR +: 8] <= (avs_writedata_in[SER_ADDR +: 8] > ADDR_MAX) ?
        ADDR_MAX : avs_writedata_in[SER_ADDR +: 8];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      a1_low_reg <= THR_LOW_RST;
      a1_high_reg <= THR_HIGH_RST;
      a2_low_reg <= THR_LOW_RST;
      a2_high_reg <= THR_HIGH_RST;
    end else if (wr_go) begin
      if (avs_address_in == OFF_A1_LOW) begin
        a1_low_reg <= clamp_thr(avs_writedata_in[15:0]);
      end
      if (avs_address_in == OFF_A1_HIGH) begin
        a1_high_reg <= clamp_thr(avs_writedata_in[15:0]);
      end
      if (avs_address_in == OFF_A2_LOW) begin
        a2_low_reg <= clamp_thr(avs_writedata_in[15:0]);
      end
      if (avs_address_in == OFF_A2_HIGH) begin
        a2_high_reg <= clamp_thr(avs_writedata_in[15:0]);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      value_reg <= 16'h0000;
    end else if (wr_go && avs_address_in == OFF_VALUE) begin
      value_reg <= clamp_thr(avs_writedata_in[15:0]);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      display_value_out <= 16'h0000;
    end else begin
      display_value_out <= value_reg;
    end
  end

  // ---------------- alarms
  assign alarm_clear = (menu_in & (key_up_in | key_down_in)) |
                       (wr_go && avs_address_in == OFF_ALM_RST);

  rdasc_alarm u_alarm_one (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .enable_in(ctrl_reg[CTRL_A1_EN]),
    .mode_in(ctrl_reg[CTRL_A1_MODE +: 2]),
    .latched_in(ctrl_reg[CTRL_LATCH]),
    .clear_in(alarm_clear),
    .value_in(value_reg),
    .low_in(a1_low_reg),
    .high_in(a1_high_reg),
    .active_out(alarm_act[0])
  );

  rdasc_alarm u_alarm_two (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .enable_in(ctrl_reg[CTRL_A2_EN]),
    .mode_in(ctrl_reg[CTRL_A2_MODE +: 2]),
    .latched_in(ctrl_reg[CTRL_LATCH]),
    .clear_in(alarm_clear),
    .value_in(value_reg),
    .low_in(a2_low_reg),
    .high_in(a2_high_reg),
    .active_out(alarm_act[1])
  );
  assign alarm_out = alarm_act;

  // alarm one takes the display when both are active
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      colour_out <= COL_GREEN;
    end else if (alarm_act[0]) begin
      colour_out <= ctrl_reg[CTRL_A1_COL +: 2];
    end else if (alarm_act[1]) begin
      colour_out <= ctrl_reg[CTRL_A2_COL +: 2];
    end else begin
      colour_out <= ctrl_reg[CTRL_IDLE_COL +: 2];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      alarm_prev_reg <= 2'h0;
    end else begin
      alarm_prev_reg <= alarm_act;
    end
  end

  // ---------------- serial link
  assign host_flow = serial_reg[SER_HOST];
  assign baud_sel = serial_reg[SER_BAUD +: 3];
  assign fmt_sel = serial_reg[SER_FMT +: 2];
  assign std_sel = serial_reg[SER_STD +: 2];
  assign addr_sel = serial_reg[SER_ADDR +: 8];
  // rates double from the slowest, so the bit time halves per step
  assign bit_cycles = TMR_W'(BIT_CYCLES_SLOW >> baud_sel);

  rdasc_uart #(.CW(TMR_W)) u_uart (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .bit_cycles_in(bit_cycles),
    .format_in(fmt_sel),
    .tx_start_in(tx_start),
    .tx_data_in(tx_data),
    .tx_busy_out(tx_busy),
    .txd_out(txd_out),
    .rxd_in(rxd_in),
    .rx_valid_out(rx_valid),
    .rx_data_out(rx_data),
    .rx_err_out(rx_err)
  );

  // multi-point: a byte equal to the address arms the next byte
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      addr_armed_reg <= 1'b0;
    end else if (std_sel != STD_485) begin
      addr_armed_reg <= 1'b0;
    end else if (rx_valid && !rx_err && !tx_busy) begin
      addr_armed_reg <= !addr_armed_reg && (rx_data == addr_sel);
    end
  end

  // half duplex 485 ignores its own echo
  assign rx_accept = rx_valid && !rx_err &&
    ((std_sel != STD_485) || (addr_armed_reg && !tx_busy));

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rx_data_reg <= 8'h00;
    end else if (rx_accept) begin
      rx_data_reg <= rx_data;
    end
  end

  // a command requests one frame; the request beats its own clearing
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      req_pending_reg <= 1'b0;
    end else if (rx_accept && rx_data == CMD_SEND && !host_flow) begin
      req_pending_reg <= 1'b1;
    end else if ((tx_start && tx_state_reg != TX_HI) || host_flow) begin
      req_pending_reg <= 1'b0;
    end
  end

  assign frame_go = host_flow | req_pending_reg;
  assign frame_done = (tx_state_reg == TX_LO) && !tx_busy;

  always_comb begin
    unique case (tx_state_reg)
      TX_IDLE: tx_start = frame_go;
      TX_HI: tx_start = !tx_busy;
      TX_LO: tx_start = !tx_busy && frame_go;
      default: tx_start = 1'b0;
    endcase
  end
  assign tx_data = (tx_state_reg == TX_HI) ? frame_val_reg[7:0] : value_reg[15:8];

  // frame: high byte then low byte, restarted back to back in host flow
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_state_reg <= TX_IDLE;
    end else begin
      unique case (tx_state_reg)
        TX_IDLE: begin
          if (frame_go) begin
            tx_state_reg <= TX_HI;
          end
        end
        TX_HI: begin
          if (!tx_busy) begin
            tx_state_reg <= TX_LO;
          end
        end
        TX_LO: begin
          if (!tx_busy) begin
            tx_state_reg <= frame_go ? TX_HI : TX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      frame_val_reg <= 16'h0000;
    end else if (tx_start && tx_state_reg != TX_HI) begin
      frame_val_reg <= value_reg;
    end
  end

  // point-to-point standards keep the driver on; 485 only while sending
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_oe_out <= 1'b0;
    end else begin
      tx_oe_out <= (std_sel != STD_485) || tx_busy || tx_start;
    end
  end

  // ---------------- interrupts
  assign irq_evt = {rx_valid & rx_err, rx_accept, frame_done, alarm_act & ~alarm_prev_reg};
  assign irq_clr = (wr_go && avs_address_in == OFF_IRQ_CLR) ?
    avs_writedata_in[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      irq_en_reg <= '0;
    end else if (wr_go && avs_address_in == OFF_IRQ_EN) begin
      irq_en_reg <= avs_writedata_in[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_reg & irq_en_reg);
    end
  end
endmodule : rdasc_top

// File: src/rdasc_uart.sv
// serial character transmitter and receiver, ten bit frames
`timescale 1ns/1ps
module rdasc_uart import rdasc_pkg::*; #(
  parameter int CW = TMR_W
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [CW-1:0] bit_cycles_in,
  input wire logic [1:0] format_in,
  input wire logic tx_start_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_busy_out,
  output logic txd_out,
  input wire logic rxd_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_err_out
);
  logic [9:0] tx_sh_reg;
  logic [3:0] tx_cnt_reg;
  logic [CW-1:0] tx_tmr_reg;
  logic [9:0] rx_sh_reg;
  logic [3:0] rx_cnt_reg;
  logic [CW-1:0] rx_tmr_reg;
  // ninth frame bit: parity for seven bit formats, msb otherwise
  function automatic logic bit_eight(input logic [7:0] d, input logic [1:0] f);
    if (f == FMT_7O1) begin
      return ~^d[6:0];
    end else if (f == FMT_7E1) begin
      return ^d[6:0];
    end
    return d[7];
  endfunction : bit_eight
  // no handshake lines: a start is sent as soon as asked
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_sh_reg <= 10'h3FF;
      tx_cnt_reg <= 4'h0;
      tx_tmr_reg <= '0;
    end else if (tx_cnt_reg == 4'h0) begin
      if (tx_start_in) begin
        tx_sh_reg <= {1'b1, bit_eight(tx_data_in, format_in), tx_data_in[6:0], 1'b0};
        tx_cnt_reg <= 4'hA;
        tx_tmr_reg <= bit_cycles_in - 1'b1;
      end
    end else if (tx_tmr_reg == '0) begin
      tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
      tx_cnt_reg <= tx_cnt_reg - 4'h1;
      tx_tmr_reg <= bit_cycles_in - 1'b1;
    end else begin
      tx_tmr_reg <= tx_tmr_reg - 1'b1;
    end
  end
  assign txd_out = tx_sh_reg[0];
  assign tx_busy_out = tx_cnt_reg != 4'h0;
  // receiver samples mid bit; a start bit that does not hold is dropped
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rx_sh_reg <= 10'h000;
      rx_cnt_reg <= 4'h0;
      rx_tmr_reg <= '0;
      rx_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= (rx_cnt_reg == 4'h1) && (rx_tmr_reg == '0);
      if (rx_cnt_reg == 4'h0) begin
        if (!rxd_in) begin
          rx_cnt_reg <= 4'hA;
          rx_tmr_reg <= bit_cycles_in >> 1;
        end
      end else if (rx_tmr_reg == '0) begin
        rx_sh_reg <= {rxd_in, rx_sh_reg[9:1]};
        rx_tmr_reg <= bit_cycles_in - 1'b1;
        rx_cnt_reg <= (rx_cnt_reg == 4'hA && rxd_in) ? 4'h0 : rx_cnt_reg - 4'h1;
      end else begin
        rx_tmr_reg <= rx_tmr_reg - 1'b1;
      end
    end
  end
  assign rx_data_out = (format_in == FMT_8N1) ? rx_sh_reg[8:1] : {1'b0, rx_sh_reg[7:1]};
  assign rx_err_out = ~rx_sh_reg[9] |
    ((format_in != FMT_8N1) && (rx_sh_reg[8] != bit_eight(rx_sh_reg[8:1], format_in)));
endmodule : rdasc_uart

// File: verif/rdasc_peer.sv
// serial instrument on the far side of the link
`timescale 1ns/1ps
module rdasc_peer (
  input wire logic clk_in,
  input wire logic txd_in,
  output logic rxd_out
);
  initial rxd_out = 1'b1;
  // start, seven data bits and parity or eight data bits, lsb first, stop; no handshake
  task automatic send(input logic [7:0] b, input int bt, input logic [1:0] fmt);
    logic [9:0] f;
    f = {1'b1, (fmt == 2'h2) ? b[7] : (^b[6:0] ^ (fmt == 2'h0)), b[6:0], 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_out <= f[i];
      repeat ((i == 9) ? 1 : bt) @(posedge clk_in);
    end
  endtask : send
  // catch one eight bit character, sampled mid-bit
  task automatic recv(input int bt, output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (txd_in !== 1'b0 && n < 40 * bt) begin
      @(negedge clk_in);
      n++;
    end
    if (txd_in === 1'b0) begin
      ok = 1'b1;
      repeat (bt + bt / 2) @(negedge clk_in);
      for (int i = 0; i < 8; i++) begin
        b[i] = txd_in;
        repeat (bt) @(negedge clk_in);
      end
    end
  endtask : recv
endmodule : rdasc_peer

// File: verif/rdasc_sva.sv
// checker on the top module ports
`timescale 1ns/1ps
module rdasc_sva import rdasc_pkg::*; #(
  parameter int BIT_CYCLES_SLOW = BIT_CYCLES_300
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic menu_in,
  input wire logic txd_out,
  input wire logic tx_oe_out,
  input wire logic [1:0] alarm_out,
  input wire logic [1:0] colour_out,
  input wire logic [15:0] display_value_out,
  input wire logic irq_out
);
  localparam int LOW_MAX = 9 * BIT_CYCLES_SLOW + 4;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  int low_run;
  // length of the current low stretch on the transmit line
  always_ff @(posedge clk_in) begin
    if (!nrst_in || txd_out) low_run <= 0;
    else low_run <= low_run + 1;
  end
  one_wait_a: assert property ($rose(avs_read_in || avs_write_in) |->
    avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("wait state count wrong");
  idle_wait_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("waitrequest without request");
  data_stand_a: assert property ($changed(avs_readdata_out) |-> $past(avs_read_in))
    else $error("read data moved without read");
  reset_out_a: assert property ($rose(nrst_in) |-> alarm_out == 2'h0 && colour_out == 2'h0
    && display_value_out == 16'h0 && irq_out == 1'b0 && txd_out ##1 tx_oe_out)
    else $error("outputs wrong after reset");
  alarm_cause_a: assert property ($changed(alarm_out) |-> $past(avs_write_in) ||
    $past(avs_write_in, 2) || $past(menu_in) || $past(menu_in, 2))
    else $error("alarm changed without cause");
  disp_write_a: assert property ($changed(display_value_out) |->
    $past(avs_write_in) || $past(avs_write_in, 2)) else $error("display moved without write");
  oe_drive_a: assert property (!txd_out |-> tx_oe_out)
    else $error("line driven low while driver off");
  frame_len_a: assert property (low_run <= LOW_MAX)
    else $error("transmit line low too long");
endmodule : rdasc_sva

// File: verif/tb_top.sv
// bench: bus master, alarm, interrupt and serial scenarios
`timescale 1ns/1ps
module tb_top import rdasc_pkg::*;;
  localparam int BC = 256;
  localparam logic [1:0] MT [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
  localparam logic [31:0] VT [7] = '{32'hFFFF, 32'h0, 32'h3E8, 32'h3E9, 32'hFFFF, 32'h3E9,
    32'h1F4};
  localparam logic [6:0] AT = 7'h39;
  logic clk_in, nrst_in, avs_read_in, avs_write_in, menu_in, key_up_in, key_down_in;
  logic avs_waitrequest_out, rxd_in, txd_out, tx_oe_out, irq_out, ok;
  logic [AW-1:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic [1:0] alarm_out, colour_out;
  logic [15:0] display_value_out;
  logic [7:0] b;
  int mismatches, n_checks;
  rdasc_top #(.BIT_CYCLES_SLOW(BC)) uut (.clk_in, .nrst_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .menu_in,
    .key_up_in, .key_down_in, .rxd_in, .txd_out, .tx_oe_out, .alarm_out, .colour_out,
    .display_value_out, .irq_out);
  // a released line floats to its idle high level at the far end
  rdasc_peer peer (.clk_in, .txd_in(tx_oe_out ? txd_out : 1'b1), .rxd_out(rxd_in));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task acc(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do begin
      @(posedge clk_in);
      n++;
      q = avs_readdata_out;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (avs_waitrequest_out !== 1'b0) begin
      chk(n, 0, "bus timeout");
      results();
    end else begin
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
    end
  endtask : acc
  task wr(input logic [AW-1:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr
  task rdc(input logic [AW-1:0] a, input logic [31:0] e, input string nm);
    acc(1'b0, a, 32'h0);
    chk(q, e, nm);
  endtask : rdc
  task al(input logic [1:0] ea, input logic [1:0] ec);
    repeat (3) @(negedge clk_in);
    chk({30'h0, alarm_out}, {30'h0, ea}, "alarm");
    chk({30'h0, colour_out}, {30'h0, ec}, "colour");
  endtask : al
  task quiet(input int c);
    int n;
    n = 0;
    repeat (c) begin
      @(negedge clk_in);
      if (txd_out !== 1'b1) n++;
    end
    chk(n, 0, "line quiet");
  endtask : quiet
  initial begin
    nrst_in = 1'b0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 6'h00;
    avs_writedata_in = 32'h0;
    menu_in = 1'b0;
    key_up_in = 1'b0;
    key_down_in = 1'b0;
    mismatches = 0;
    n_checks = 0;
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    rdc(OFF_CTRL, 32'h0500, "ctrl");
    rdc(OFF_SERIAL, 32'h002A, "serial");
    rdc(OFF_A1_HIGH, 32'h03E8, "a1 high");
    rdc(6'h3C, 32'h0, "unmapped");
    wr(OFF_A1_LOW, 32'h8000);
    rdc(OFF_A1_LOW, 32'hFFFFFC19, "low clamp");
    wr(OFF_A2_HIGH, 32'h7FFF);
    rdc(OFF_A2_HIGH, 32'h270F, "high clamp");
    wr(OFF_A1_LOW, 32'h0);
    wr(OFF_A2_HIGH, 32'h3E8);
    for (int i = 0; i < 7; i++) begin
      wr(OFF_CTRL, 32'h0501 | {MT[i], 2'h0});
      wr(OFF_VALUE, VT[i]);
      al({1'b0, AT[i]}, {1'b0, AT[i]});
      chk(display_value_out, VT[i][15:0], "display");
    end
    wr(OFF_CTRL, 32'h1912);
    wr(OFF_VALUE, 32'h3E9);
    al(2'h2, COL_AMBER);
    wr(OFF_VALUE, 32'h5);
    al(2'h0, COL_RED);
    wr(OFF_IRQ_CLR, 32'h1F);
    wr(OFF_IRQ_EN, 32'h1);
    wr(OFF_CTRL, 32'h0541);
    chk(irq_out, 1'b0, "irq clear");
    for (int k = 0; k < 2; k++) begin
      wr(OFF_VALUE, 32'hFFFB);
      wr(OFF_VALUE, 32'h5);
      al(2'h1, COL_RED);
      @(posedge clk_in);
      key_up_in <= ~k[0];
      key_down_in <= k[0];
      al(2'h1, COL_RED);
      @(posedge clk_in);
      menu_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      menu_in <= 1'b0;
      key_up_in <= 1'b0;
      key_down_in <= 1'b0;
      al(2'h0, COL_GREEN);
    end
    chk(irq_out, 1'b1, "irq raised");
    rdc(OFF_IRQ_STAT, 32'h1, "irq status");
    wr(OFF_IRQ_CLR, 32'h1);
    wr(OFF_IRQ_EN, 32'h0);
    wr(OFF_VALUE, 32'hFFFB);
    wr(OFF_VALUE, 32'h5);
    wr(OFF_ALM_RST, 32'h1);
    al(2'h0, COL_GREEN);
    chk(irq_out, 1'b0, "irq masked");
    rdc(OFF_IRQ_STAT, 32'h1, "irq status");
    wr(OFF_VALUE, 32'h1234);
    wr(OFF_SERIAL, 32'h20);
    quiet(800);
    peer.send(8'h3F, BC, FMT_8N1);
    peer.recv(BC, b, ok);
    chk({23'h0, ok, b}, 32'h112, "poll byte");
    peer.recv(BC, b, ok);
    chk({23'h0, ok, b}, 32'h134, "poll byte");
    wr(OFF_SERIAL, 32'h21);
    for (int k = 0; k < 4; k++) begin
      peer.recv(BC, b, ok);
      chk({23'h0, ok, b}, k[0] ? 32'h134 : 32'h112, "host byte");
    end
    wr(OFF_SERIAL, 32'h20);
    repeat (1500) @(posedge clk_in);
    wr(OFF_SERIAL, 32'h12A0);
    repeat (2) @(negedge clk_in);
    chk(tx_oe_out, 1'b0, "driver off");
    peer.send(8'h3F, BC, FMT_8N1);
    quiet(1500);
    peer.send(8'h12, BC, FMT_8N1);
    repeat (BC) @(posedge clk_in);
    peer.send(8'h3F, BC, FMT_8N1);
    peer.recv(BC, b, ok);
    chk({23'h0, ok, b}, 32'h112, "addressed byte");
    rdc(OFF_RX_DATA, 32'h3F, "rx data");
    repeat (12 * BC) @(posedge clk_in);
    for (int i = 0; i < 7; i++) begin
      wr(OFF_SERIAL, (i << 1) | ((i % 3) << 4));
      peer.send(8'(8'h30 + i), BC >> i, 2'(i % 3));
      repeat (BC) @(posedge clk_in);
      rdc(OFF_RX_DATA, 32'h30 + i, "rx rate");
    end
    peer.send(8'h55, BC >> 6, FMT_7E1);
    repeat (BC) @(posedge clk_in);
    rdc(OFF_RX_DATA, 32'h36, "bad parity");
    results();
  end
endmodule : tb_top
bind rdasc_top rdasc_sva #(.BIT_CYCLES_SLOW(BIT_CYCLES_SLOW)) chk_i (.clk_in, .nrst_in,
  .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .menu_in, .txd_out,
  .tx_oe_out, .alarm_out, .colour_out, .display_value_out, .irq_out);
